// ==== tsp_pkg.sv ====
// Constants, register map and types for the tape status and packing block
package tsp_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COUNT  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_STW1   = 8'h0C;
  localparam logic [7:0] REG_STW2   = 8'h10;
  localparam logic [7:0] REG_WDATA  = 8'h14;
  localparam logic [7:0] REG_RDATA  = 8'h18;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTRL_START   = 0;
  localparam int CTRL_OP_LO   = 1;
  localparam int CTRL_IE      = 3;
  localparam int CTRL_CHAIN   = 4;
  localparam int CTRL_NEXT_OK = 5;
  localparam int CTRL_NEXT_OP = 6;
  localparam int CTRL_NEXT_IE = 8;
  localparam int CTRL_ABORT   = 9;
  // ----------------------------------------
  // Status word one bits
  // ----------------------------------------
  localparam int STW_OC  = 0;
  localparam int STW_EOR = 6;
  localparam int STW_CE  = 14;
  localparam int STW_LT  = 15;
  // ----------------------------------------
  // Data layout
  // ----------------------------------------
  localparam int CHAR_W = 8;
  localparam int WORD_W = 16;
  localparam logic [7:0] ODD_FILL = 8'hFF;
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_RDB = 2'h1;
  localparam logic [1:0] OP_WRB = 2'h2;
  localparam int FIFO_DEPTH = 8;
  typedef enum {ST_IDLE, ST_XFER, ST_STAT1, ST_STAT2} tsp_state_t;
endpackage

// ==== tsp_top.sv ====
// Tape status reporting, character packing and word buffer
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// ----------------------------------------
module tsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module tsp_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [8:0]  tape_rd_char,
  input  wire logic        tape_rd_strobe,
  input  wire logic        tape_eor,
  output logic      [8:0]  tape_wr_char,
  output logic             tape_wr_strobe,
  input  wire logic        tape_wr_ready,
  output logic             busy,
  output logic             irq_req,
  output logic             two_status_words
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [10:0] sy1_r;
  logic [10:0] sy2_r;
  logic        rs_d_r;
  logic        wr_d_r;
  logic        wr_q_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sy1_r  <= '0;
      sy2_r  <= '0;
      rs_d_r <= 1'b0;
      wr_q_r <= 1'b0;
      wr_d_r <= 1'b0;
    end else begin
      sy1_r  <= {tape_eor, tape_rd_strobe, tape_rd_char};
      sy2_r  <= sy1_r;
      rs_d_r <= sy2_r[9];
      wr_q_r <= tape_wr_ready;
      wr_d_r <= wr_q_r;
    end
  end
  logic [8:0] rd_char;
  logic       rd_pulse;
  logic       eor_s;
  logic       wr_rdy_m;
  assign rd_char  = sy2_r[8:0];
  assign rd_pulse = sy2_r[9] && !rs_d_r;
  assign eor_s    = sy2_r[10];
  // ----------------------------------------
  // Control state
  // ----------------------------------------
  tsp_pkg::tsp_state_t st_r;
  logic [15:0] ctrl_r;
  logic [15:0] count_r;
  logic [15:0] stw1_r;
  logic [15:0] stw2_r;
  logic [15:0] rdata_r;
  logic        rvalid_r;
  logic        hi_r;
  logic [7:0]  hold_r;
  logic        stat_ie_r;
  logic        two_r;
  logic        eor_hit_r;
  logic        aborted_r;
  logic        lt_r;
  logic [1:0]  op;
  logic        wr_acc;
  logic        rd_acc;
  logic        start;
  logic        xfer_op;
  logic        chain_ok;
  logic        chain_bad;
  logic [15:0] f_out;
  logic        f_ov;
  logic        f_ir;
  logic        f_pop;
  logic        pe_ok;
  assign op      = ctrl_r[tsp_pkg::CTRL_OP_LO +: 2];
  assign xfer_op = (op == tsp_pkg::OP_RDB) || (op == tsp_pkg::OP_WRB);
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign start   = wr_acc && (paddr == tsp_pkg::REG_CTRL) && pwdata[tsp_pkg::CTRL_START] && (st_r == tsp_pkg::ST_IDLE);
  assign chain_ok  = ctrl_r[tsp_pkg::CTRL_CHAIN] && ctrl_r[tsp_pkg::CTRL_NEXT_OK]
                     && (ctrl_r[tsp_pkg::CTRL_NEXT_OP +: 2] == op);
  assign chain_bad = ctrl_r[tsp_pkg::CTRL_CHAIN] && ctrl_r[tsp_pkg::CTRL_NEXT_OK]
                     && (ctrl_r[tsp_pkg::CTRL_NEXT_OP +: 2] != op);
  assign busy    = (st_r != tsp_pkg::ST_IDLE);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_rdy_m = wr_d_r;
  assign pe_ok    = ^rd_char;
  logic done_now;
  assign done_now = (count_r == '0) || eor_s || ctrl_r[tsp_pkg::CTRL_ABORT];
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r      <= tsp_pkg::ST_IDLE;
      stw1_r    <= '0;
      stw2_r    <= '0;
      stat_ie_r <= 1'b0;
      two_r     <= 1'b0;
      eor_hit_r <= 1'b0;
      aborted_r <= 1'b0;
      lt_r      <= 1'b0;
    end else begin
      case (st_r)
        tsp_pkg::ST_IDLE: begin
          if (start) begin
            st_r      <= (pwdata[tsp_pkg::CTRL_OP_LO +: 2] == tsp_pkg::OP_NOP) ? tsp_pkg::ST_STAT1 : tsp_pkg::ST_XFER;
            eor_hit_r <= 1'b0;
            aborted_r <= 1'b0;
            lt_r      <= 1'b0;
            two_r     <= 1'b0;
            stw1_r    <= (pwdata[tsp_pkg::CTRL_OP_LO +: 2] == tsp_pkg::OP_NOP) ? 16'h0001 << tsp_pkg::STW_OC : 16'h0000;
            stat_ie_r <= pwdata[tsp_pkg::CTRL_IE];
          end
        end
        tsp_pkg::ST_XFER: begin
          if (done_now) begin
            if (count_r == '0 && chain_ok && !ctrl_r[tsp_pkg::CTRL_ABORT]) begin
              st_r      <= tsp_pkg::ST_STAT1;
              stw1_r    <= 16'h0001 << tsp_pkg::STW_LT;
              lt_r      <= 1'b1;
              stat_ie_r <= ctrl_r[tsp_pkg::CTRL_NEXT_IE];
            end else begin
              st_r      <= tsp_pkg::ST_STAT1;
              two_r     <= xfer_op;
              eor_hit_r <= eor_s && (op == tsp_pkg::OP_RDB);
              aborted_r <= ctrl_r[tsp_pkg::CTRL_ABORT] || chain_bad;
              stw1_r    <= ((count_r == '0 && !chain_bad) ? 16'h0001 << tsp_pkg::STW_OC : 16'h0000)
                         | ((eor_s) ? 16'h0001 << tsp_pkg::STW_EOR : 16'h0000)
                         | ((chain_bad) ? 16'h0001 << tsp_pkg::STW_CE : 16'h0000);
              stat_ie_r <= ctrl_r[tsp_pkg::CTRL_IE];
            end
          end
        end
        tsp_pkg::ST_STAT1: begin
          if (two_r) begin
            st_r   <= tsp_pkg::ST_STAT2;
            stw2_r <= (eor_hit_r || aborted_r) ? count_r : 16'h0000;
          end else begin
            st_r <= lt_r ? tsp_pkg::ST_XFER : tsp_pkg::ST_IDLE;
            lt_r <= 1'b0;
          end
        end
        tsp_pkg::ST_STAT2: begin
          st_r <= tsp_pkg::ST_IDLE;
        end
        default: begin
          st_r <= tsp_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign irq_req          = (st_r == tsp_pkg::ST_STAT1) && stat_ie_r;
  assign two_status_words = (st_r != tsp_pkg::ST_IDLE) && two_r;
  // ----------------------------------------
  // Character packing
  // ----------------------------------------
  assign f_pop = f_ov && (st_r == tsp_pkg::ST_XFER) && (op == tsp_pkg::OP_WRB) && wr_rdy_m && !tape_wr_strobe;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r        <= '0;
      hi_r           <= 1'b1;
      hold_r         <= '0;
      rdata_r        <= '0;
      rvalid_r       <= 1'b0;
      tape_wr_char   <= '0;
      tape_wr_strobe <= 1'b0;
    end else begin
      tape_wr_strobe <= 1'b0;
      if (wr_acc && paddr == tsp_pkg::REG_COUNT && st_r == tsp_pkg::ST_IDLE) begin
        count_r <= pwdata[15:0];
      end
      if (start) begin
        hi_r     <= 1'b1;
        rvalid_r <= 1'b0;
      end
      if (rd_acc && paddr == tsp_pkg::REG_RDATA) begin
        rvalid_r <= 1'b0;
      end
      if (st_r == tsp_pkg::ST_XFER && op == tsp_pkg::OP_WRB && f_pop && count_r != '0) begin
        tape_wr_char   <= {~^(hi_r ? f_out[15:8] : f_out[7:0]), hi_r ? f_out[15:8] : f_out[7:0]};
        tape_wr_strobe <= 1'b1;
        count_r        <= count_r - 16'h0001;
        hi_r           <= 1'b1;
      end
      if (st_r == tsp_pkg::ST_XFER && op == tsp_pkg::OP_RDB && rd_pulse && count_r != '0 && pe_ok) begin
        count_r <= count_r - 16'h0001;
        if (hi_r) begin
          hold_r <= rd_char[7:0];
          hi_r   <= 1'b0;
          if (count_r == 16'h0001) begin
            rdata_r  <= {rd_char[7:0], tsp_pkg::ODD_FILL};
            rvalid_r <= 1'b1;
            hi_r     <= 1'b1;
          end
        end else begin
          rdata_r  <= {hold_r, rd_char[7:0]};
          rvalid_r <= 1'b1;
          hi_r     <= 1'b1;
        end
      end
    end
  end
  // Write words pass through the fifo; odd last word only sends its upper byte
  logic wr_half_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_half_r <= 1'b0;
    end else if (start) begin
      wr_half_r <= 1'b0;
    end else if (f_pop && count_r != '0) begin
      wr_half_r <= ~wr_half_r && (count_r != 16'h0001);
    end
  end
  logic [15:0] f_out_raw;
  logic        f_pop_word;
  assign f_out      = wr_half_r ? {f_out_raw[7:0], 8'h00} : f_out_raw;
  assign f_pop_word = f_pop && count_r != '0 && (wr_half_r || count_r == 16'h0001);
  tsp_fifo #(.WIDTH(tsp_pkg::WORD_W), .DEPTH(tsp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (pwdata[15:0]),
    .in_valid  (wr_acc && paddr == tsp_pkg::REG_WDATA),
    .in_ready  (f_ir),
    .out_data  (f_out_raw),
    .out_valid (f_ov),
    .out_ready (f_pop_word)
  );
  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      tsp_pkg::REG_CTRL:   prdata = {16'h0000, ctrl_r};
      tsp_pkg::REG_COUNT:  prdata = {16'h0000, count_r};
      tsp_pkg::REG_STATUS: prdata = {27'h0, f_ir, f_ov, rvalid_r, two_r, busy};
      tsp_pkg::REG_STW1:   prdata = {16'h0000, stw1_r};
      tsp_pkg::REG_STW2:   prdata = {16'h0000, stw2_r};
      tsp_pkg::REG_RDATA:  prdata = {16'h0000, rdata_r};
      default:             prdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= '0;
    end else if (wr_acc && paddr == tsp_pkg::REG_CTRL) begin
      if (busy) begin
        ctrl_r[tsp_pkg::CTRL_ABORT] <= pwdata[tsp_pkg::CTRL_ABORT];
      end else begin
        ctrl_r <= {pwdata[15:1], 1'b0};
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_stat_two;
    (st_r == tsp_pkg::ST_STAT1) && two_r ##1 (st_r == tsp_pkg::ST_STAT2);
  endsequence
  AST_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
    ((st_r == tsp_pkg::ST_STAT1) && two_r) |-> s_stat_two) else $error("second word not next");
  AST_BUSY: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == tsp_pkg::ST_STAT2) |=> !busy) else $error("busy after final store");
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    ((st_r == tsp_pkg::ST_STAT1) && two_r && !eor_hit_r && !aborted_r) |=> (stw2_r == 16'h0000)) else $error("nonzero word2");
  AST_LTGO: assert property (@(posedge clk_sys) disable iff (rst)
    ((st_r == tsp_pkg::ST_STAT1) && lt_r && !two_r) |=> (st_r == tsp_pkg::ST_XFER)) else $error("list taken aborted");
  AST_ODD: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(rvalid_r) && $past(count_r) == 16'h0001 && $past(hi_r) |-> rdata_r[7:0] == 8'hFF) else $error("odd fill");
  AST_PAR: assert property (@(posedge clk_sys) disable iff (rst)
    tape_wr_strobe |-> ^tape_wr_char) else $error("bad parity");
  AST_TWO: assert property (@(posedge clk_sys) disable iff (rst)
    ((st_r == tsp_pkg::ST_STAT1) && !lt_r && xfer_op) |-> two_r) else $error("missing word2");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
    irq_req |-> stat_ie_r && busy) else $error("irq without enable");
endmodule
`default_nettype wire

// ==== tsp_tape_model.sv ====
// Tape transport model facing the packing block
`timescale 1ns/10ps
`default_nettype none
module tsp_tape_model (
  input  wire logic       clk_sys,
  input  wire logic       stall,
  output logic      [8:0] tape_rd_char,
  output logic            tape_rd_strobe,
  output logic            tape_eor,
  output logic            tape_wr_ready
);
  initial begin
    tape_rd_char   = 9'h0A5;
    tape_rd_strobe = 1'h0;
    tape_eor       = 1'h0;
  end
  // Ready is the inverse of the commanded stall
  assign tape_wr_ready = ~stall;
  // One odd-parity character, then the line scrambles
  task automatic send_char(input logic [7:0] c);
    @(posedge clk_sys);
    tape_rd_char <= {~^c, c};
    repeat (2) @(posedge clk_sys);
    tape_rd_strobe <= 1'h1;
    repeat (4) @(posedge clk_sys);
    tape_rd_strobe <= 1'h0;
    repeat (4) @(posedge clk_sys);
    tape_rd_char <= ~tape_rd_char;
  endtask
  task automatic end_record(input logic v);
    @(posedge clk_sys);
    tape_eor <= v;
  endtask
endmodule
`default_nettype wire

// ==== tsp_top_tb.sv ====
// Self-checking bench for the tape status and packing block
`timescale 1ns/10ps
`default_nettype none
module tsp_top_tb;
  logic        clk_sys, pready, pslverr, tape_rd_strobe, tape_eor, tape_wr_strobe;
  logic        tape_wr_ready, busy, irq_req, two_status_words;
  logic        rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stall = 1'h0;
  logic        irq_seen = 1'h0, tsw_seen = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [8:0]  tape_rd_char, tape_wr_char;
  logic [8:0]  exp_q[$];
  logic [15:0] w[9];
  int          bad_count = 0, compares = 0, cyc = 0, seed = 53168, i, k;
  localparam int LIMIT = 20000;
  tsp_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tape_rd_char, .tape_rd_strobe, .tape_eor, .tape_wr_char, .tape_wr_strobe, .tape_wr_ready,
    .busy, .irq_req, .two_status_words);
  tsp_tape_model tape (.clk_sys, .stall, .tape_rd_char, .tape_rd_strobe, .tape_eor, .tape_wr_ready);
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [8:0] pc(input logic [7:0] c);
    return {~^c, c};
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] op, input logic ie = 1'h0, input logic ch = 1'h0,
                                      input logic nok = 1'h0, input logic [1:0] nop = 2'h0, input logic nie = 1'h0);
    return {22'h0, 1'h0, nie, nop, nok, ch, ie, op, 1'h1};
  endfunction
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    v = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'h1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    apb(1'h0, a, 32'h0, v);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, output logic [31:0] v);
    v = 32'h0;
    for (int n = 0; n < 300 && (v & m) == 32'h0; n++) rd(a, v);
  endtask
  task automatic rdw(input logic [15:0] e);
    logic [31:0] v;
    poll(tsp_pkg::REG_STATUS, 32'h4, v);
    rd(tsp_pkg::REG_RDATA, v);
    chk("rdata", {16'h0, e}, v);
  endtask
  task automatic push(input logic [15:0] v, input int n);
    exp_q.push_back(pc(v[15:8]));
    if (n > 1) exp_q.push_back(pc(v[7:0]));
  endtask
  task automatic go(input logic [15:0] n, input logic [31:0] c);
    irq_seen = 1'h0;
    tsw_seen = 1'h0;
    wr(tsp_pkg::REG_COUNT, {16'h0, n});
    wr(tsp_pkg::REG_CTRL, c);
    repeat (2) @(posedge clk_sys);
    if (c[2:1] != 2'h0) chk("busy_start", 32'h1, {31'h0, busy});
  endtask
  task automatic idle;
    for (int n = 0; n < 3000 && busy !== 1'h0; n++) @(posedge clk_sys);
    chk("busy_end", 32'h0, {31'h0, busy});
  endtask
  task automatic stat(input logic [15:0] s2, input int b);
    rd(tsp_pkg::REG_STW2, r);
    chk("stw2", {16'h0, s2}, r);
    rd(tsp_pkg::REG_STW1, r);
    if (b >= 0) chk("stw1_bit", 32'h1, {31'h0, r[b]});
  endtask
  // ----------------------------------------
  // Output watcher and timeout
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (irq_req === 1'h1) irq_seen <= 1'h1;
    if (two_status_words === 1'h1) tsw_seen <= 1'h1;
    if (tape_wr_strobe === 1'h1) begin
      if (exp_q.size() == 0) chk("tape_extra", 32'h0, 32'h1);
      else chk("tape_char", {23'h0, exp_q.pop_front()}, {23'h0, tape_wr_char});
    end
    if (cyc == LIMIT) begin
      bad_count++;
      final_report;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    for (i = 0; i < 9; i++) begin
      w[i] = 16'($random(seed));
      wr(tsp_pkg::REG_WDATA, {16'h0, w[i]});
    end
    rd(tsp_pkg::REG_STATUS, r);
    chk("buffer_full", 32'h0, {31'h0, r[4]});
    wr(8'h40, 32'($random(seed)));
    rd(8'h40, r);
    chk("unmapped", 32'h0, r);
    for (i = 0; i < 8; i++) push(w[i], 2);
    stall <= 1'h1;
    go(16'h10, ctl(tsp_pkg::OP_WRB));
    repeat (40) @(posedge clk_sys);
    stall <= 1'h0;
    idle;
    chk("queue_left", 32'h0, 32'(exp_q.size()));
    stat(16'h0, tsp_pkg::STW_OC);
    chk("two_words", 32'h1, {31'h0, tsw_seen});
    $display("test long_write done");
    for (i = 0; i < 2; i++) wr(tsp_pkg::REG_WDATA, {16'h0, w[i]});
    push(w[0], 2);
    push(w[1], 1);
    go(16'h3, ctl(tsp_pkg::OP_WRB));
    idle;
    chk("queue_left", 32'h0, 32'(exp_q.size()));
    stat(16'h0, tsp_pkg::STW_OC);
    $display("test odd_write done");
    go(16'h3, ctl(tsp_pkg::OP_RDB));
    tape.send_char(w[2][15:8]);
    tape.send_char(w[2][7:0]);
    rdw(w[2]);
    tape.send_char(w[3][15:8]);
    rdw({w[3][15:8], tsp_pkg::ODD_FILL});
    idle;
    stat(16'h0, tsp_pkg::STW_OC);
    chk("two_words", 32'h1, {31'h0, tsw_seen});
    $display("test odd_read done");
    go(16'h4, ctl(tsp_pkg::OP_RDB));
    tape.send_char(w[4][7:0]);
    tape.end_record(1'h1);
    idle;
    tape.end_record(1'h0);
    stat(16'h3, tsp_pkg::STW_EOR);
    go(16'h4, ctl(tsp_pkg::OP_WRB));
    repeat (10) @(posedge clk_sys);
    wr(tsp_pkg::REG_CTRL, 32'h200);
    idle;
    stat(16'h4, -1);
    $display("test residual done");
    go(16'h0, ctl(tsp_pkg::OP_NOP));
    idle;
    rd(tsp_pkg::REG_STW1, r);
    chk("nop_done", 32'h1, {31'h0, r[tsp_pkg::STW_OC]});
    chk("one_word", 32'h0, {31'h0, tsw_seen});
    $display("test no_op done");
    for (k = 0; k < 8; k++) begin
      wr(tsp_pkg::REG_WDATA, {16'h0, w[k]});
      push(w[k], 2);
      go(16'h2, ctl(tsp_pkg::OP_WRB, k[0], 1'h1, 1'h1, k[2] ? tsp_pkg::OP_RDB : tsp_pkg::OP_WRB, k[1]));
      if (k[2]) begin
        idle;
        chk("ce_irq", {31'h0, k[0]}, {31'h0, irq_seen});
        rd(tsp_pkg::REG_STW1, r);
        chk("ce_bit", 32'h1, {31'h0, r[tsp_pkg::STW_CE]});
      end else begin
        poll(tsp_pkg::REG_STW1, 32'h8000, r);
        chk("lt_bit", 32'h1, {31'h0, r[tsp_pkg::STW_LT]});
        @(posedge clk_sys);
        chk("lt_irq", {31'h0, k[1]}, {31'h0, irq_seen});
        wr(tsp_pkg::REG_CTRL, 32'h200);
        idle;
      end
    end
    wr(tsp_pkg::REG_WDATA, {16'h0, w[8]});
    push(w[8], 2);
    go(16'h2, ctl(tsp_pkg::OP_WRB, 1'h0, 1'h1, 1'h0, tsp_pkg::OP_WRB, 1'h1));
    idle;
    rd(tsp_pkg::REG_STW1, r);
    chk("no_lt", 32'h0, {31'h0, r[tsp_pkg::STW_LT]});
    $display("test chaining done");
    final_report;
  end
endmodule
`default_nettype wire
